// ===== common/por_seq_map.svh
`ifndef POR_SEQ_MAP_SVH
`define POR_SEQ_MAP_SVH

// Register byte offsets
`define OFS_CFG 8'h00
`define OFS_KEEP 8'h04
`define OFS_VNORM 8'h08
`define OFS_VFORCE 8'h0C
`define OFS_WRSEL 8'h10
`define OFS_STATUS 8'h14

// Configuration field positions
`define CFG_AUTO 0
`define CFG_OFF_HW 1
`define CFG_OFF_COLD 2
`define CFG_RSTIN_COLD 3
`define CFG_GATE_BYP 4
`define CFG_OSC_BYP 5

// Reset values
`define CFG_RST 6'h01
`define WRSEL_RST 1'b0

// Auto-shutdown window, slow clock rate
`define HOLD_WINDOW_S 8
`define SLOW_HZ 32768
`define HOLD_TICKS (`HOLD_WINDOW_S * `SLOW_HZ)

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== common/por_seq_pkg.sv
package por_seq_pkg;

  typedef enum logic [4:0] {
    st_off = 5'h01,
    st_up = 5'h02,
    st_act = 5'h04,
    st_slp = 5'h08,
    st_dn = 5'h10
  } pwr_state_t;

  // One-hot sequence kind
  typedef enum logic [2:0] {
    seq_o2a = 3'h1,
    seq_a2o = 3'h2,
    seq_s2o = 3'h4
  } seq_kind_t;

  typedef struct packed {
    logic osc_bypass;
    logic gate_bypass;
    logic rstin_cold;
    logic off_cold;
    logic off_hardware_level_reset;
    logic auto_keepalive_mode;
  } cfg_t;

  typedef struct packed {
    logic set_sel;
    logic [1:0] seq_sel;
  } boot_sel_t;

endpackage

// ===== design/power_on_reset_sequencer.sv
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

`include "por_seq_map.svh"

module power_on_reset_sequencer
  import por_seq_pkg::*;
#(
  parameter int HOLD_TICKS = `HOLD_TICKS
)
(
  // Clock and power-on reset
  input wire logic clock,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Host-facing pins
  input wire logic on_request,
  input wire logic hold_on_pin,
  input wire logic warm_reset_pin_n,
  input wire logic reset_in,
  input wire logic sleep_request,
  input wire logic boot_select_first,
  input wire logic boot_select_second,
  output logic reset_out,
  // Clock status
  input wire logic slow_tick,
  input wire logic xtal_stable,
  input wire logic ext32k_stable,
  // OTP voltage codes per set
  input wire logic [6:0] otp_vcode_set0,
  input wire logic [6:0] otp_vcode_set1,
  // Sequencer engine
  output logic seq_start,
  output logic [2:0] seq_kind,
  output logic [1:0] seq_sel,
  output logic set_sel,
  output logic [1:0] seq_branch,
  output logic warm_run,
  input wire logic seq_done,
  // Reset level strobes and voltage outputs
  output logic hardware_level_reset,
  output logic switchoff_level_reset,
  output logic [6:0] vcode_normal,
  output logic [6:0] vcode_forced
);

  pwr_state_t state;
  pwr_state_t next_state;
  cfg_t cfg;
  boot_sel_t boot;
  logic boot_taken;
  logic keepalive_bit;
  logic wrsel;
  logic held;
  logic cold_pend;
  logic warm_d;
  logic vload;
  logic [19:0] win_cnt;
  logic go_seq;
  seq_kind_t go_kind;
  logic hw_hit;
  logic swo_hit;
  logic warm_go;
  logic take_boot;
  logic cold_now;

  // Event decode
  wire clk_ok = cfg.gate_bypass
    || (cfg.osc_bypass ? ext32k_stable : xtal_stable);
  wire hold_any = hold_on_pin || keepalive_bit;
  wire win_exp = (win_cnt == HOLD_TICKS[19:0]);
  wire rel_off = !hold_any && (held || win_exp);
  wire off_evt = rel_off || reset_in;
  wire warm_evt = warm_d && !warm_reset_pin_n;
  wire enter_act = (state == st_up) && seq_done;
  wire [6:0] otp_code = boot.set_sel ? otp_vcode_set1 : otp_vcode_set0;
  wire v_reload = vload || hw_hit || swo_hit || (warm_go && wrsel);

  // Bus decode
  wire wr_go = awvalid && wvalid && !bvalid;
  wire rd_go = arvalid && !rvalid;
  wire wr_cfg = wr_go && wstrb[0] && (awaddr == `OFS_CFG);
  wire wr_keep = wr_go && wstrb[0] && (awaddr == `OFS_KEEP);
  wire wr_vn = wr_go && wstrb[0] && (awaddr == `OFS_VNORM);
  wire wr_vf = wr_go && wstrb[0] && (awaddr == `OFS_VFORCE);
  wire wr_ws = wr_go && wstrb[0] && (awaddr == `OFS_WRSEL);
  wire wr_hit = (awaddr == `OFS_CFG) || (awaddr == `OFS_KEEP)
    || (awaddr == `OFS_VNORM) || (awaddr == `OFS_VFORCE)
    || (awaddr == `OFS_WRSEL) || (awaddr == `OFS_STATUS);
  wire rd_hit = (araddr == `OFS_CFG) || (araddr == `OFS_KEEP)
    || (araddr == `OFS_VNORM) || (araddr == `OFS_VFORCE)
    || (araddr == `OFS_WRSEL) || (araddr == `OFS_STATUS);
  wire [31:0] status_word = {21'h00_0000, held, boot_taken, boot.seq_sel,
    boot.set_sel, reset_out, state};
  wire [31:0] rd_mux =
    (araddr == `OFS_CFG) ? {26'h000_0000, cfg} :
    (araddr == `OFS_KEEP) ? {31'h0000_0000, keepalive_bit} :
    (araddr == `OFS_VNORM) ? {25'h000_0000, vcode_normal} :
    (araddr == `OFS_VFORCE) ? {25'h000_0000, vcode_forced} :
    (araddr == `OFS_WRSEL) ? {31'h0000_0000, wrsel} :
    (araddr == `OFS_STATUS) ? status_word : 32'h0000_0000;

  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = rd_go;

  always_comb
  begin
    next_state = state;
    go_seq = 1'b0;
    go_kind = seq_o2a;
    hw_hit = 1'b0;
    swo_hit = 1'b0;
    warm_go = 1'b0;
    take_boot = 1'b0;
    cold_now = 1'b0;
    case (state)
      st_off:
      begin
        if (on_request && !reset_in)
        begin
          take_boot = !boot_taken;
          go_seq = 1'b1;
          next_state = st_up;
        end
      end
      st_up:
      begin
        if (seq_done)
          next_state = st_act;
      end
      st_act, st_slp:
      begin
        if (off_evt)
        begin
          go_seq = 1'b1;
          go_kind = (state == st_act) ? seq_a2o : seq_s2o;
          hw_hit = cfg.off_hardware_level_reset;
          swo_hit = !cfg.off_hardware_level_reset;
          cold_now = reset_in ? cfg.rstin_cold : cfg.off_cold;
          next_state = st_dn;
        end
        else if (warm_evt)
        begin
          go_seq = 1'b1;
          warm_go = 1'b1;
          next_state = st_up;
        end
        else if (state == st_act && sleep_request)
          next_state = st_slp;
        else if (state == st_slp && !sleep_request)
          next_state = st_act;
      end
      st_dn:
      begin
        if (seq_done)
        begin
          if (cold_pend && !reset_in)
          begin
            go_seq = 1'b1;
            next_state = st_up;
          end
          else
            next_state = st_off;
        end
      end
      default:
        next_state = st_off;
    endcase
  end

  // Power-on domain: state, config, boot selection
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= st_off;
      cfg <= `CFG_RST;
      boot <= '0;
      boot_taken <= 1'b0;
      warm_d <= 1'b1;
    end
    else
    begin
      state <= next_state;
      warm_d <= warm_reset_pin_n;
      if (wr_cfg)
        cfg <= wdata[5:0];
      if (take_boot)
      begin
        boot_taken <= 1'b1;
        boot.set_sel <= boot_select_first;
        boot.seq_sel <= boot_select_first ? 2'h2 :
          (boot_select_second ? 2'h1 : 2'h0);
      end
    end
  end

  // Hardware domain: keep-alive bit and its window
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      keepalive_bit <= 1'b0;
    else if (enter_act && cfg.auto_keepalive_mode)
      keepalive_bit <= 1'b1;
    else if (hw_hit)
      keepalive_bit <= 1'b0;
    else if (wr_keep)
      keepalive_bit <= wdata[0];
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      held <= 1'b0;
      win_cnt <= 20'h0_0000;
    end
    // Held survives sleep, so a pin drop there still means OFF
    else if (enter_act || (state != st_act && state != st_slp))
    begin
      held <= 1'b0;
      win_cnt <= 20'h0_0000;
    end
    else if (hold_any)
      held <= 1'b1;
    else if (!held && slow_tick && !win_exp && state == st_act)
      win_cnt <= win_cnt + 20'h0_0001;
  end

  // Switch-off domain: voltage codes and warm reload select
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      vload <= 1'b1;
      wrsel <= `WRSEL_RST;
      vcode_normal <= 7'h00;
      vcode_forced <= 7'h00;
    end
    else
    begin
      vload <= 1'b0;
      if (hw_hit || swo_hit)
        wrsel <= `WRSEL_RST;
      else if (wr_ws)
        wrsel <= wdata[0];
      if (v_reload)
      begin
        vcode_normal <= otp_code;
        vcode_forced <= otp_code;
      end
      else
      begin
        if (wr_vn)
          vcode_normal <= wdata[6:0];
        if (wr_vf)
          vcode_forced <= wdata[6:0];
      end
    end
  end

  // Sequencer handoff and reset strobes
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      seq_start <= 1'b0;
      seq_kind <= seq_o2a;
      warm_run <= 1'b0;
      cold_pend <= 1'b0;
      hardware_level_reset <= 1'b0;
      switchoff_level_reset <= 1'b0;
      seq_branch <= 2'h0;
    end
    else
    begin
      seq_start <= go_seq;
      hardware_level_reset <= hw_hit;
      switchoff_level_reset <= swo_hit;
      seq_branch <= {boot_select_second, boot_select_first};
      if (go_seq)
      begin
        seq_kind <= go_kind;
        warm_run <= warm_go;
      end
      if (state != st_dn)
        cold_pend <= cold_now;
    end
  end

  assign seq_sel = boot.seq_sel;
  assign set_sel = boot.set_sel;

  // Host reset release
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      reset_out <= 1'b0;
    else
      reset_out <= (next_state == st_act || next_state == st_slp)
        && clk_ok;
  end

  // AXI response channels
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (bready)
      bvalid <= 1'b0;
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rvalid <= 1'b0;
      rresp <= `RESP_OKAY;
      rdata <= 32'h0000_0000;
    end
    else if (rd_go)
    begin
      rvalid <= 1'b1;
      rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      rdata <= rd_mux;
    end
    else if (rready)
      rvalid <= 1'b0;
  end

endmodule

// ===== testbench/por_seq_asserts.sv
`timescale 1ns/1ps
module por_seq_asserts (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Host pins
  input wire logic reset_in,
  input wire logic boot_select_first,
  input wire logic boot_select_second,
  input wire logic reset_out,
  // Sequencer engine
  input wire logic seq_start,
  input wire logic [2:0] seq_kind,
  input wire logic [1:0] seq_sel,
  input wire logic set_sel,
  input wire logic [1:0] seq_branch,
  input wire logic warm_run,
  input wire logic seq_done,
  // Level strobes
  input wire logic hardware_level_reset,
  input wire logic switchoff_level_reset
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_off;
    seq_start && seq_kind != 3'h1;
  endsequence
  sequence s_strobe;
    hardware_level_reset || switchoff_level_reset;
  endsequence
  property p_release;
    $rose(reset_out) |-> $past(seq_done);
  endproperty
  a_release: assert property (p_release) else $error("reset_out rose without done");
  property p_start_pulse;
    seq_start |=> !seq_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("seq_start too long");
  property p_gate;
    $past(reset_in) |-> !(seq_start && seq_kind == 3'h1);
  endproperty
  a_gate: assert property (p_gate) else $error("start while reset_in");
  property p_off_level;
    s_off |-> ##[0:1] s_strobe;
  endproperty
  a_off_level: assert property (p_off_level) else $error("off without level strobe");
  property p_hw_once;
    hardware_level_reset |-> !switchoff_level_reset ##1 !hardware_level_reset;
  endproperty
  a_hw_once: assert property (p_hw_once) else $error("bad hardware strobe");
  property p_warm;
    seq_start && warm_run |-> seq_kind == 3'h1;
  endproperty
  a_warm: assert property (p_warm) else $error("warm run not off_to_active");
  property p_boot_hold;
    reset_out |-> $stable(seq_sel) && $stable(set_sel);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("boot choice moved");
  property p_boot_map;
    set_sel == (seq_sel == 2'h2) && seq_sel != 2'h3;
  endproperty
  a_boot_map: assert property (p_boot_map) else $error("set and sequence disagree");
  property p_branch;
    !$past(sys_rst) |-> seq_branch == {$past(boot_select_second), $past(boot_select_first)};
  endproperty
  a_branch: assert property (p_branch) else $error("branch not live pins");
endmodule

// ===== testbench/power_on_reset_sequencer_tb.sv
`timescale 1ns/1ps
`include "por_seq_map.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module power_on_reset_sequencer_tb;
  logic clock = 0, sys_rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rd;
  logic [3:0] wstrb = 4'hf;
  logic on_request = 0, hold_on_pin = 0, warm_reset_pin_n = 1, reset_in = 0, sleep_request = 0;
  logic boot_select_first = 0, boot_select_second = 1, slow_tick = 0, xtal_stable = 1;
  logic ext32k_stable = 0, eng_slow = 0;
  logic [6:0] otp_vcode_set0 = 7'h2a, otp_vcode_set1 = 7'h15;
  logic [1:0] rr;
  wire awready, wready, bvalid, arready, rvalid, reset_out, seq_start, set_sel, warm_run;
  wire seq_done, hardware_level_reset, switchoff_level_reset;
  wire [1:0] bresp, rresp, seq_sel, seq_branch;
  wire [31:0] rdata;
  wire [2:0] seq_kind;
  wire [6:0] vcode_normal, vcode_forced;
  int errors = 0, checks = 0, cyc = 0, hw_cnt = 0, sw_cnt = 0, st_cnt = 0;
  power_on_reset_sequencer #(.HOLD_TICKS(20)) i_power_on_reset_sequencer (.clock, .sys_rst,
    .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .on_request, .hold_on_pin,
    .warm_reset_pin_n, .reset_in, .sleep_request, .boot_select_first, .boot_select_second,
    .reset_out, .slow_tick, .xtal_stable, .ext32k_stable, .otp_vcode_set0, .otp_vcode_set1,
    .seq_start, .seq_kind, .seq_sel, .set_sel, .seq_branch, .warm_run, .seq_done,
    .hardware_level_reset, .switchoff_level_reset, .vcode_normal, .vcode_forced);
  seq_engine_model i_seq_engine_model (.clock, .sys_rst, .seq_start, .slow(eng_slow),
    .seq_done);
  initial forever #5 clock = ~clock;
  always @(posedge clock)
  begin
    cyc++;
    slow_tick <= (cyc % 4 == 3);
    if (cyc == 6000)
    begin
      errors++;
      final_report();
    end
  end
  // Strobe counts, taken mid-cycle while each strobe stands
  always @(negedge clock)
  begin
    hw_cnt += (hardware_level_reset === 1'b1);
    sw_cnt += (switchoff_level_reset === 1'b1);
    st_cnt += (seq_start === 1'b1);
  end
  task final_report;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do @(posedge clock); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 0;
    wvalid <= 0;
    do @(posedge clock); while (bvalid !== 1'b1);
    bready <= 0;
  endtask
  task axr(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge clock); while (rvalid !== 1'b1);
    rd = rdata;
    rr = rresp;
    rready <= 0;
  endtask
  task pulse_on;
    @(posedge clock);
    on_request <= 1;
    @(posedge clock);
    on_request <= 0;
  endtask
  task wait_ro(input logic v);
    while (reset_out !== v) @(negedge clock);
    if (!v)
      while (seq_done !== 1'b1) @(negedge clock);
    @(posedge clock);
  endtask
  task t_regs;
    axr(`OFS_CFG);
    `CHK("cfg", 32'h1, rd)
    axr(`OFS_VFORCE);
    `CHK("vforce", {25'h0, otp_vcode_set0}, rd)
    `CHK("vnorm", otp_vcode_set0, vcode_normal)
    axw(`OFS_VNORM, 32'h55);
    `CHK("vnorm_w", 7'h55, vcode_normal)
    axr(8'h18);
    `CHK("unmapped", `RESP_SLVERR, rr)
  endtask
  task t_hold;
    axw(`OFS_CFG, 32'h0);
    pulse_on();
    wait_ro(1);
    `CHK("seq_sel", 2'h1, seq_sel)
    `CHK("set_sel", 1'b0, set_sel)
    hold_on_pin <= 1;
    sleep_request <= 1;
    repeat (150) @(posedge clock);
    `CHK("held", 1'b1, reset_out)
    hold_on_pin <= 0;
    wait_ro(0);
    sleep_request <= 0;
    `CHK("slp_off", 3'h4, seq_kind)
    `CHK("swo_strobe", 1, sw_cnt)
    `CHK("hw_none", 0, hw_cnt)
    `CHK("reload", otp_vcode_set0, vcode_normal)
  endtask
  task t_timeout;
    int n;
    n = 0;
    pulse_on();
    wait_ro(1);
    while (reset_out === 1'b1 && n < 200)
    begin
      @(posedge clock);
      n++;
    end
    `CHK("window", 1'b1, n >= 76 && n <= 100)
    `CHK("expired", 2, sw_cnt)
    wait_ro(0);
  endtask
  task t_auto;
    axw(`OFS_CFG, 32'h3);
    pulse_on();
    wait_ro(1);
    axr(`OFS_KEEP);
    `CHK("keep", 32'h1, rd)
    axw(`OFS_WRSEL, 32'h1);
    axw(`OFS_VNORM, 32'h11);
    repeat (150) @(posedge clock);
    `CHK("kept", 1'b1, reset_out)
    eng_slow <= 1;
    warm_reset_pin_n <= 0;
    repeat (30) @(posedge clock);
    `CHK("warm", 1'b1, warm_run)
    `CHK("warm_act", 1'b1, reset_out)
    `CHK("warm_sel", 2'h1, seq_sel)
    `CHK("warm_reload", otp_vcode_set0, vcode_normal)
    warm_reset_pin_n <= 1;
    reset_in <= 1;
    wait_ro(0);
    `CHK("hw_strobe", 1, hw_cnt)
    axr(`OFS_KEEP);
    `CHK("keep_clr", 32'h0, rd)
    axr(`OFS_WRSEL);
    `CHK("wrsel_clr", 32'h0, rd)
    axr(`OFS_CFG);
    `CHK("cfg_kept", 32'h3, rd)
  endtask
  task t_resetin;
    int s;
    s = st_cnt;
    reset_in <= 1;
    pulse_on();
    repeat (20) @(posedge clock);
    `CHK("blocked", s, st_cnt)
    `CHK("blocked_ro", 1'b0, reset_out)
    reset_in <= 0;
  endtask
  task t_keep;
    pulse_on();
    wait_ro(1);
    axw(`OFS_KEEP, 32'h1);
    repeat (150) @(posedge clock);
    `CHK("keep_hold", 1'b1, reset_out)
    hold_on_pin <= 1;
    axw(`OFS_KEEP, 32'h0);
    repeat (20) @(posedge clock);
    `CHK("other_on", 1'b1, reset_out)
    hold_on_pin <= 0;
    wait_ro(0);
    `CHK("keep_off", 3, sw_cnt)
  endtask
  task t_clock;
    int s;
    axw(`OFS_CFG, 32'h20);
    pulse_on();
    repeat (40) @(posedge clock);
    `CHK("no_clk", 1'b0, reset_out)
    repeat (80) @(posedge clock);
    `CHK("no_clk_off", 4, sw_cnt)
    axw(`OFS_CFG, 32'h34);
    pulse_on();
    wait_ro(1);
    `CHK("gate_byp", 1'b1, reset_out)
    wait_ro(0);
    wait_ro(1);
    `CHK("cold", 5, sw_cnt)
    reset_in <= 1;
    wait_ro(0);
    s = st_cnt;
    repeat (5) @(posedge clock);
    reset_in <= 0;
    `CHK("no_restart", s, st_cnt)
  endtask
  initial
  begin
    repeat (8) @(posedge clock);
    sys_rst <= 0;
    @(posedge clock);
    t_regs();
    t_hold();
    t_timeout();
    t_keep();
    t_clock();
    t_auto();
    t_resetin();
    final_report();
  end
endmodule
bind power_on_reset_sequencer por_seq_asserts i_por_seq_asserts (.clock, .sys_rst, .reset_in,
  .boot_select_first, .boot_select_second, .reset_out, .seq_start, .seq_kind, .seq_sel,
  .set_sel, .seq_branch, .warm_run, .seq_done, .hardware_level_reset, .switchoff_level_reset);

// ===== testbench/seq_engine_model.sv
`timescale 1ns/1ps
module seq_engine_model (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Engine handshake
  input wire logic seq_start,
  input wire logic slow,
  output logic seq_done
);
  logic [3:0] left;
  // Ends each run after a short or long delay
  always_ff @(posedge clock or posedge sys_rst)
    if (sys_rst)
    begin
      left <= 4'h0;
      seq_done <= 1'b0;
    end
    else
    begin
      seq_done <= (left == 4'h1);
      if (seq_start)
        left <= slow ? 4'hc : 4'h2;
      else if (left != 4'h0)
        left <= left - 4'h1;
    end
endmodule
